// ---- rtl/cps_defs.vh ----
/*
 constants for the camera two-wire pin steering block.
 assumes inclusion by bare name from the rtl files that need them.
*/
`ifndef CPS_DEFS_VH
`define CPS_DEFS_VH

// slave address base, eight-bit form with the read/write bit at bit 0
`define CPS_ADDR_BASE 8'h60
// position of the port select bit in the control byte
`define CPS_SEL_BIT 0
// reset value of the control byte, port a selected
`define CPS_CTRL_RST 8'h00
// bits per byte on the bus
`define CPS_BYTE_BITS 4'h8
// width of the synchroniser bundle
`define CPS_SYNC_W 5

`endif

// ---- rtl/cps_sync2.v ----
/*
 two flip-flop synchroniser for the pins of the steering block.
 assumes its inputs are asynchronous to mclk; the first stage feeds only the second.
*/
`timescale 1ns/1ns
`include "cps_defs.vh"

module cps_sync2
(
   input wire mclk,
   input wire arst_n,
   input wire [`CPS_SYNC_W-1:0] async_in,
   output reg [`CPS_SYNC_W-1:0] sync_out
);

reg [`CPS_SYNC_W-1:0] meta_q;

always @(posedge mclk or negedge arst_n)
begin
   if (!arst_n)
   begin
      meta_q <= {`CPS_SYNC_W{1'b1}};
      sync_out <= {`CPS_SYNC_W{1'b1}};
   end
   else
   begin
      meta_q <= async_in;
      sync_out <= meta_q;
   end
end

endmodule // cps_sync2

// ---- rtl/cps_pin_steer.v ----
/*
 two-wire slave pin front end: data in/out pins, drive monitor, camera clock steering,
 strap address and a one-byte control register written over the bus.
 assumes all pins are asynchronous to mclk and that the bus runs far slower than mclk.
*/
`timescale 1ns/1ns
`include "cps_defs.vh"

module cps_pin_steer
(
   input wire mclk,
   input wire arst_n,
   input wire bus_data_in,
   input wire bus_clock_in,
   input wire addr_strap_bit1,
   input wire addr_strap_bit2,
   input wire addr_strap_bit3,
   output reg bus_data_out_od,
   output reg bus_data_out_od_oe,
   output reg bus_data_drive_monitor,
   output reg cam_a_clock_out,
   output reg cam_b_clock_out
);

localparam [6:0] ST_IDLE = 7'h01;
localparam [6:0] ST_ADDR = 7'h02;
localparam [6:0] ST_AACK = 7'h04;
localparam [6:0] ST_WDAT = 7'h08;
localparam [6:0] ST_WACK = 7'h10;
localparam [6:0] ST_RDAT = 7'h20;
localparam [6:0] ST_RACK = 7'h40;

wire [`CPS_SYNC_W-1:0] pins_s;
wire sda_s;
wire scl_s;
reg sda_prev_q;
reg scl_prev_q;
wire scl_rise;
wire scl_fall;
wire start_cond;
wire stop_cond;
reg [6:0] st_q;
reg [6:0] st_d;
reg [3:0] cnt_q;
reg [3:0] cnt_d;
reg [7:0] sh_q;
reg [7:0] sh_d;
reg [7:0] tx_q;
reg [7:0] tx_d;
reg [7:0] ctrl_q;
reg [7:0] ctrl_d;
reg [7:0] pend_q;
reg [7:0] pend_d;
reg pend_vld_q;
reg pend_vld_d;
reg drive_d;
wire sel_b;
wire [7:0] own_addr;

// strap-weighted slave address, eight-bit form
function [7:0] slave_addr;
   input b3;
   input b2;
   input b1;
   begin
      slave_addr = `CPS_ADDR_BASE | {4'h0, b3, b2, b1, 1'b0};
   end
endfunction

cps_sync2 u_sync
(
   .mclk(mclk),
   .arst_n(arst_n),
   .async_in({addr_strap_bit3, addr_strap_bit2, addr_strap_bit1, bus_clock_in, bus_data_in}),
   .sync_out(pins_s)
);

assign sda_s = pins_s[0];
assign scl_s = pins_s[1];
assign scl_rise = scl_s & ~scl_prev_q;
assign scl_fall = ~scl_s & scl_prev_q;
assign start_cond = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
assign stop_cond = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
assign sel_b = ctrl_q[`CPS_SEL_BIT];
assign own_addr = slave_addr(pins_s[4], pins_s[3], pins_s[2]);

always @*
begin
   st_d = st_q;
   cnt_d = cnt_q;
   sh_d = sh_q;
   tx_d = tx_q;
   ctrl_d = ctrl_q;
   pend_d = pend_q;
   pend_vld_d = pend_vld_q;
   drive_d = bus_data_out_od_oe;
   if (stop_cond)
   begin
      st_d = ST_IDLE;
      drive_d = 1'b0;
      if (pend_vld_q)
      begin
         ctrl_d = pend_q;
         pend_vld_d = 1'b0;
      end
   end
   else if (start_cond)
   begin
      st_d = ST_ADDR;
      cnt_d = 4'h0;
      drive_d = 1'b0;
   end
   else
   begin
      case (st_q)
         ST_IDLE:
         begin
            drive_d = 1'b0;
         end
         ST_ADDR, ST_WDAT:
         begin
            if (scl_rise)
            begin
               sh_d = {sh_q[6:0], sda_s};
               cnt_d = cnt_q + 4'h1;
            end
            else if (scl_fall && cnt_q == `CPS_BYTE_BITS)
            begin
               cnt_d = 4'h0;
               if (st_q == ST_WDAT)
               begin
                  pend_d = sh_q;
                  pend_vld_d = 1'b1;
                  drive_d = 1'b1;
                  st_d = ST_WACK;
               end
               else if (sh_q[7:1] == own_addr[7:1])
               begin
                  drive_d = 1'b1;
                  st_d = ST_AACK;
               end
               else
               begin
                  st_d = ST_IDLE;
               end
            end
         end
         ST_AACK:
         begin
            if (scl_fall)
            begin
               if (sh_q[0])
               begin
                  tx_d = ctrl_q;
                  drive_d = ~ctrl_q[7];
                  st_d = ST_RDAT;
               end
               else
               begin
                  drive_d = 1'b0;
                  st_d = ST_WDAT;
               end
            end
         end
         ST_WACK:
         begin
            if (scl_fall)
            begin
               drive_d = 1'b0;
               st_d = ST_WDAT;
            end
         end
         ST_RDAT:
         begin
            if (scl_rise)
            begin
               cnt_d = cnt_q + 4'h1;
            end
            else if (scl_fall)
            begin
               if (cnt_q == `CPS_BYTE_BITS)
               begin
                  cnt_d = 4'h0;
                  drive_d = 1'b0;
                  st_d = ST_RACK;
               end
               else
               begin
                  tx_d = {tx_q[6:0], 1'b0};
                  drive_d = ~tx_q[6];
               end
            end
         end
         ST_RACK:
         begin
            if (scl_rise && sda_s)
            begin
               st_d = ST_IDLE;
            end
            else if (scl_fall)
            begin
               tx_d = ctrl_q;
               drive_d = ~ctrl_q[7];
               st_d = ST_RDAT;
            end
         end
         default:
         begin
            st_d = ST_IDLE;
            drive_d = 1'b0;
         end
      endcase
   end
end

always @(posedge mclk or negedge arst_n)
begin
   if (!arst_n)
   begin
      st_q <= ST_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      ctrl_q <= `CPS_CTRL_RST;
      pend_q <= 8'h00;
      pend_vld_q <= 1'b0;
      sda_prev_q <= 1'b1;
      scl_prev_q <= 1'b1;
      bus_data_out_od <= 1'b0;
      bus_data_out_od_oe <= 1'b0;
      bus_data_drive_monitor <= 1'b1;
      cam_a_clock_out <= 1'b1;
      cam_b_clock_out <= 1'b1;
   end
   else
   begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      tx_q <= tx_d;
      ctrl_q <= ctrl_d;
      pend_q <= pend_d;
      pend_vld_q <= pend_vld_d;
      sda_prev_q <= sda_s;
      scl_prev_q <= scl_s;
      bus_data_out_od <= 1'b0;
      bus_data_out_od_oe <= drive_d;
      bus_data_drive_monitor <= ~drive_d;
      cam_a_clock_out <= sel_b ? 1'b1 : scl_s;
      cam_b_clock_out <= sel_b ? scl_s : 1'b1;
   end
end

endmodule // cps_pin_steer

// ---- dv/cps_pin_steer_properties.sv ----
/*
 checker for the pin steering block.
 assumes only the top ports; bound below.
*/
`timescale 1ns/1ns
module cps_pin_steer_chk
(
   input wire mclk,
   input wire arst_n,
   input wire bus_clock_in,
   input wire bus_data_out_od,
   input wire bus_data_out_od_oe,
   input wire bus_data_drive_monitor,
   input wire cam_a_clock_out,
   input wire cam_b_clock_out
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   sequence s_a_up;
      ##3 cam_a_clock_out;
   endsequence
   mon_low_a: assert property (bus_data_out_od_oe |-> !bus_data_drive_monitor)
      else $error("monitor high while pulling");
   mon_high_a: assert property (!bus_data_out_od_oe |-> bus_data_drive_monitor)
      else $error("monitor low while released");
   od_low_a: assert property (bus_data_out_od_oe |-> !bus_data_out_od)
      else $error("data driven high");
   one_low_a: assert property (cam_a_clock_out || cam_b_clock_out)
      else $error("both camera clocks low");
   a_follow_a: assert property (!cam_a_clock_out |-> !$past(bus_clock_in, 3))
      else $error("port a clock low without bus clock");
   b_follow_a: assert property (!cam_b_clock_out |-> !$past(bus_clock_in, 3))
      else $error("port b clock low without bus clock");
   a_rise_a: assert property (!cam_a_clock_out && $rose(bus_clock_in) |-> s_a_up)
      else $error("port a clock not released");
   oe_edge_a: assert property ($rose(bus_data_out_od_oe) |-> !$past(bus_clock_in, 3))
      else $error("data drive off clock low");
endmodule // cps_pin_steer_chk

bind cps_pin_steer cps_pin_steer_chk i_chk (.mclk(mclk), .arst_n(arst_n),
   .bus_clock_in(bus_clock_in), .bus_data_out_od(bus_data_out_od),
   .bus_data_out_od_oe(bus_data_out_od_oe), .bus_data_drive_monitor(bus_data_drive_monitor),
   .cam_a_clock_out(cam_a_clock_out), .cam_b_clock_out(cam_b_clock_out));

// ---- dv/cps_host_model.sv ----
/*
 host two-wire master model.
 assumes a pulled-up data wire resolved by the bench.
*/
`timescale 1ns/1ns
module cps_host_model
(
   input wire mclk,
   input wire sda_wire,
   output reg scl,
   output reg sda
);
   initial
   begin
      scl = 1'b1;
      sda = 1'b1;
   end
   task hp;
      repeat (4) @(negedge mclk);
   endtask
   task start;
      hp;
      sda = 1'b0;
      hp;
      scl = 1'b0;
   endtask
   task stop;
      sda = 1'b0;
      hp;
      scl = 1'b1;
      hp;
      sda = 1'b1;
      hp;
   endtask
   task xfer(input [7:0] d, input mack, output [7:0] q, output ack);
      integer i;
      for (i = 7; i >= 0; i = i - 1)
      begin
         sda = d[i];
         hp;
         scl = 1'b1;
         hp;
         q[i] = sda_wire;
         scl = 1'b0;
      end
      sda = mack;
      hp;
      scl = 1'b1;
      hp;
      ack = sda_wire;
      scl = 1'b0;
   endtask
endmodule // cps_host_model

// ---- dv/cps_pin_steer_tb.sv ----
/*
 self-checking bench for the pin steering block.
 assumes the host model on a pulled-up data line.
*/
`timescale 1ns/1ns
module cps_pin_steer_tb;
   reg mclk;
   reg arst_n;
   reg [2:0] strap;
   wire scl, sda_m, sda_w, od, oe, mon, cam_a, cam_b;
   integer fail_count;
   integer tests_run;
   integer k;
   reg [7:0] q;
   reg a;
   reg cur_sel;
   assign sda_w = sda_m & (oe ? od : 1'b1);
   cps_host_model i_host (.mclk(mclk), .sda_wire(sda_w), .scl(scl), .sda(sda_m));
   cps_pin_steer i_dut (.mclk(mclk), .arst_n(arst_n), .bus_data_in(sda_w),
      .bus_clock_in(scl), .addr_strap_bit1(strap[0]), .addr_strap_bit2(strap[1]),
      .addr_strap_bit3(strap[2]), .bus_data_out_od(od), .bus_data_out_od_oe(oe),
      .bus_data_drive_monitor(mon), .cam_a_clock_out(cam_a), .cam_b_clock_out(cam_b));
   task chk(input string n, input [7:0] e, input [7:0] s);
      tests_run = tests_run + 1;
      if (s !== e)
      begin
         fail_count = fail_count + 1;
         $display("[FAIL] %0s expected %h seen %h", n, e, s);
      end
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task t_write(input [2:0] s);
      strap = s;
      i_host.start;
      i_host.xfer({4'h6, s, 1'b0}, 1'b1, q, a);
      chk("addr ack", 8'h00, {7'h00, a});
      i_host.xfer({7'h00, s[0]}, 1'b1, q, a);
      chk("data ack", 8'h00, {7'h00, a});
      repeat (4) @(negedge mclk);
      chk("cam a before stop", {7'h00, cur_sel}, {7'h00, cam_a});
      cur_sel = s[0];
      i_host.stop;
   endtask
   task t_steer(input sel);
      i_host.scl = 1'b0;
      repeat (5) @(negedge mclk);
      chk("cam a", {7'h00, sel}, {7'h00, cam_a});
      chk("cam b", {7'h00, ~sel}, {7'h00, cam_b});
      i_host.scl = 1'b1;
   endtask
   task t_read(input [2:0] s);
      i_host.start;
      i_host.xfer({4'h6, s, 1'b1}, 1'b1, q, a);
      i_host.xfer(8'hff, 1'b1, q, a);
      chk("read", {7'h00, s[0]}, q);
      i_host.stop;
   endtask
   task t_nack;
      strap = 3'h0;
      i_host.start;
      i_host.xfer(8'h62, 1'b1, q, a);
      chk("wrong addr", 8'h01, {7'h00, a});
      i_host.stop;
   endtask
   initial
   begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   initial
   begin
      fail_count = 0;
      tests_run = 0;
      arst_n = 1'b0;
      strap = 3'h0;
      cur_sel = 1'b0;
      repeat (5) @(negedge mclk);
      arst_n = 1'b1;
      chk("idle mon", 8'h01, {7'h00, mon});
      repeat (4) @(negedge mclk);
      t_steer(1'b0);
      for (k = 0; k < 8; k = k + 1)
      begin
         t_write(k[2:0]);
         t_steer(k[0]);
         t_read(k[2:0]);
      end
      t_nack;
      end_of_test;
   end
   initial
   begin
      #2000000;
      fail_count = fail_count + 1;
      end_of_test;
   end
endmodule // cps_pin_steer_tb
